// File: verilog/rx_backplane_mode_config.sv
// receive backplane mode configuration: APB register bank and mode decode
//
// Added by the designer: the APB slave port.
`include "rx_backplane_regs.svh"
`default_nettype none
module rx_backplane_mode_config
(
  input  wire logic        CLK,
  input  wire logic        RST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // format selects toward the receive path blocks
  output logic             FRAMER_ESF,
  output logic             FRAMER_MIMIC_CRC,
  output logic             ALARM_ESF,
  output logic             SIGBUF_ESF,
  // backplane link, clocked by the system clock of the link
  input  wire logic        RX_LINK_CLOCK,
  input  wire logic        RX_COMMON_FRAME_PULSE,
  input  wire logic        RX_PAYLOAD_BIT,
  input  wire logic        RX_SIGNALING_BIT,
  output logic             RX_SYSTEM_DATA_OUT,
  output logic             RX_SYSTEM_DATA_OE,
  output logic             RX_SIGNALING_OUT,
  output logic             RX_SIGNALING_OE,
  output logic             RX_CHANNEL_FRAME_PULSE,
  output logic             RX_CHANNEL_FRAME_PULSE_OE
);

  //////////////////////////////////////////////////////////////////////////////
  // state record
  //////////////////////////////////////////////////////////////////////////////

  // every flip-flop of the register side
  typedef struct packed {
    logic [7:0]                     mode_cfg;     // interface mode register
    logic [7:0]                     pin_cfg;      // pin configuration register
    logic [7:0]                     framer_cfg;   // frame processor register
    logic [7:0]                     alarm_cfg;    // alarm detector register
    logic [7:0]                     sigbuf_cfg;   // signaling buffer register
    logic [31:0]                    prdata;       // captured read data
    logic                           pready;       // answer strobe
    logic                           pslverr;      // unmapped address flag
    logic                           framer_esf;   // decoded format selects
    logic                           framer_mimic;
    logic                           alarm_esf;
    logic                           sigbuf_esf;
    rx_backplane_pkg::link_cfg_type link_cfg;     // handed to link side
    logic                           tog_s1;       // frame toggle sync
    logic                           tog_s2;
    logic                           tog_s3;       // previous synced value
    logic                           frame_seen;   // sticky frame start flag
  } top_state_type;

  top_state_type state;       // current registers
  top_state_type next_state;  // value for the next edge

  // link side wires
  logic link_toggle;          // flips once per frame on the link clock
  logic link_data;
  logic link_data_oe;
  logic link_sig;
  logic link_sig_oe;
  logic link_pulse;
  logic link_pulse_oe;

  //////////////////////////////////////////////////////////////////////////////
  // decode helpers
  //////////////////////////////////////////////////////////////////////////////

  // map a byte address onto a register; misaligned reads as unmapped
  function automatic rx_backplane_pkg::reg_sel_type decode_reg
  (
    input logic [11:0] addr
  );
    rx_backplane_pkg::reg_sel_type sel;
    sel = rx_backplane_pkg::SEL_NONE;
    if (addr == `ADDR_OF(`IDX_MODE))
    begin
      sel = rx_backplane_pkg::SEL_MODE;
    end
    else if (addr == `ADDR_OF(`IDX_PIN))
    begin
      sel = rx_backplane_pkg::SEL_PIN;
    end
    else if (addr == `ADDR_OF(`IDX_FRAMER))
    begin
      sel = rx_backplane_pkg::SEL_FRAMER;
    end
    else if (addr == `ADDR_OF(`IDX_ALARM))
    begin
      sel = rx_backplane_pkg::SEL_ALARM;
    end
    else if (addr == `ADDR_OF(`IDX_SIGBUF))
    begin
      sel = rx_backplane_pkg::SEL_SIGBUF;
    end
    else if (addr == `ADDR_OF(`IDX_STATUS))
    begin
      sel = rx_backplane_pkg::SEL_STATUS;
    end
    return sel;
  endfunction

  // turn the mode register into a link mode; other codes park the pins
  function automatic rx_backplane_pkg::link_mode_type decode_mode
  (
    input logic [7:0] value
  );
    rx_backplane_pkg::link_mode_type mode;
    case (value)
      `MODE_SLAVE_REF: mode = rx_backplane_pkg::LINK_SLAVE_REF;
      `MODE_SIG_1544:  mode = rx_backplane_pkg::LINK_SIG_1544;
      `MODE_SIG_2048:  mode = rx_backplane_pkg::LINK_SIG_2048;
      `MODE_MASTER:    mode = rx_backplane_pkg::LINK_MASTER;
      default:         mode = rx_backplane_pkg::LINK_OFF;
    endcase
    return mode;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // next state
  //////////////////////////////////////////////////////////////////////////////

  // APB access, register writes, format and pin decode, frame flag
  always_comb
  begin
    rx_backplane_pkg::reg_sel_type   sel;
    rx_backplane_pkg::link_mode_type mode;
    logic                            slave;
    logic                            ext_sig;
    logic                            done;
    logic                            edge_seen;
    logic                            consistent;
    next_state = state;
    sel = decode_reg(PADDR);
    // access completes at the edge where pready is seen high
    done = PSEL & PENABLE & state.pready;
    // answer strobe is one cycle wide, so back to back transfers work
    next_state.pready  = 1'b0;
    next_state.pslverr = 1'b0;

    // format consistency, shown to software only
    // formats compared here
    consistent = (state.framer_cfg[`FRAMER_ESF_BIT] == state.alarm_cfg[`ALARM_ESF_BIT])
                 & (state.alarm_cfg[`ALARM_ESF_BIT] == state.sigbuf_cfg[`SIGBUF_ESF_BIT]);

    // first access cycle: fetch read data and raise the answer
    if (PSEL & PENABLE & ~state.pready)
    begin
      next_state.pready  = 1'b1;
      next_state.pslverr = (sel == rx_backplane_pkg::SEL_NONE);
      next_state.prdata  = 32'h0000_0000;
      case (sel)
        rx_backplane_pkg::SEL_MODE:   next_state.prdata[7:0] = state.mode_cfg;
        rx_backplane_pkg::SEL_PIN:    next_state.prdata[7:0] = state.pin_cfg;
        rx_backplane_pkg::SEL_FRAMER: next_state.prdata[7:0] = state.framer_cfg;
        rx_backplane_pkg::SEL_ALARM:  next_state.prdata[7:0] = state.alarm_cfg;
        rx_backplane_pkg::SEL_SIGBUF: next_state.prdata[7:0] = state.sigbuf_cfg;
        rx_backplane_pkg::SEL_STATUS:
        begin
          next_state.prdata[`STAT_SEEN_BIT]   = state.frame_seen;
          next_state.prdata[3:1]              = state.link_cfg.mode;
          next_state.prdata[`STAT_CONS_BIT]   = consistent;
        end
        default:
        begin
          // unmapped: zero data with an error answer
          next_state.prdata = 32'h0000_0000;
        end
      endcase
    end

    // frame toggle from the link side, synchronised then edge detected
    next_state.tog_s1 = link_toggle;
    next_state.tog_s2 = state.tog_s1;
    next_state.tog_s3 = state.tog_s2;
    edge_seen = state.tog_s2 ^ state.tog_s3;

    // write takes effect only at the completing edge
    if (done & PWRITE)
    begin
      case (sel)
        rx_backplane_pkg::SEL_MODE:   next_state.mode_cfg   = PWDATA[7:0];
        rx_backplane_pkg::SEL_PIN:    next_state.pin_cfg    = PWDATA[7:0];
        rx_backplane_pkg::SEL_FRAMER: next_state.framer_cfg = PWDATA[7:0];
        rx_backplane_pkg::SEL_ALARM:  next_state.alarm_cfg  = PWDATA[7:0];
        rx_backplane_pkg::SEL_SIGBUF: next_state.sigbuf_cfg = PWDATA[7:0];
        rx_backplane_pkg::SEL_STATUS:
        begin
          // write one to clear the frame flag
          if (PWDATA[`STAT_SEEN_BIT])
          begin
            next_state.frame_seen = 1'b0;
          end
        end
        default:
        begin
          // writes to unmapped addresses are dropped
          next_state.frame_seen = next_state.frame_seen;
        end
      endcase
    end

    // a frame start in the clearing cycle is kept: set wins
    if (edge_seen)
    begin
      next_state.frame_seen = 1'b1;
    end

    // format selects follow the new register values at the same edge
    // ESF with mimic CRC
    next_state.framer_esf   = next_state.framer_cfg[`FRAMER_ESF_BIT];
    next_state.framer_mimic = next_state.framer_cfg[`FRAMER_MIMIC_BIT];
    next_state.alarm_esf    = next_state.alarm_cfg[`ALARM_ESF_BIT];
    next_state.sigbuf_esf   = next_state.sigbuf_cfg[`SIGBUF_ESF_BIT];

    // interface mode and pin enables for the link side
    mode    = decode_mode(next_state.mode_cfg);
    slave   = (mode == rx_backplane_pkg::LINK_SLAVE_REF)
              | (mode == rx_backplane_pkg::LINK_SIG_1544)
              | (mode == rx_backplane_pkg::LINK_SIG_2048);
    ext_sig = (mode == rx_backplane_pkg::LINK_SIG_1544)
              | (mode == rx_backplane_pkg::LINK_SIG_2048);
    next_state.link_cfg.mode = mode;
    next_state.link_cfg.data_en =
      (slave & (next_state.pin_cfg == `PIN_SLAVE_NORM))
      | ((mode == rx_backplane_pkg::LINK_MASTER)
         & (next_state.pin_cfg == `PIN_MASTER_NORM));
    next_state.link_cfg.sig_en = ext_sig & (next_state.pin_cfg == `PIN_SLAVE_NORM);
    next_state.link_cfg.pulse_en = (mode == rx_backplane_pkg::LINK_MASTER)
                                   & (next_state.pin_cfg == `PIN_MASTER_NORM);
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers
  //////////////////////////////////////////////////////////////////////////////

  // synchronous reset to the documented power-up mode with pins released
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      state               <= '0;
      state.mode_cfg      <= `RST_MODE;
      state.pin_cfg       <= `RST_PIN;
      state.framer_cfg    <= `RST_FMT;
      state.alarm_cfg     <= `RST_FMT;
      state.sigbuf_cfg    <= `RST_FMT;
      state.link_cfg.mode <= rx_backplane_pkg::LINK_SIG_1544;
    end
    else
    begin
      state <= next_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // link clock side
  //////////////////////////////////////////////////////////////////////////////

  // config changes are rare and settle before use; each bit is two-flop
  // synchronised there, so a mode change may show one mixed link cycle
  rx_link_side link_side
  (
    .link_clk           (RX_LINK_CLOCK),
    .rst                (RST),
    .cfg                (state.link_cfg),
    .common_frame_pulse (RX_COMMON_FRAME_PULSE),
    .payload_bit        (RX_PAYLOAD_BIT),
    .signaling_bit      (RX_SIGNALING_BIT),
    .data_out           (link_data),
    .data_oe            (link_data_oe),
    .sig_out            (link_sig),
    .sig_oe             (link_sig_oe),
    .pulse_out          (link_pulse),
    .pulse_oe           (link_pulse_oe),
    .frame_toggle       (link_toggle)
  );

  //////////////////////////////////////////////////////////////////////////////
  // outputs, each straight from a flip-flop
  //////////////////////////////////////////////////////////////////////////////

  assign PRDATA                    = state.prdata;
  assign PREADY                    = state.pready;
  assign PSLVERR                   = state.pslverr;
  assign FRAMER_ESF                = state.framer_esf;
  assign FRAMER_MIMIC_CRC          = state.framer_mimic;
  assign ALARM_ESF                 = state.alarm_esf;
  assign SIGBUF_ESF                = state.sigbuf_esf;
  assign RX_SYSTEM_DATA_OUT        = link_data;
  assign RX_SYSTEM_DATA_OE         = link_data_oe;
  assign RX_SIGNALING_OUT          = link_sig;
  assign RX_SIGNALING_OE           = link_sig_oe;
  assign RX_CHANNEL_FRAME_PULSE    = link_pulse;
  assign RX_CHANNEL_FRAME_PULSE_OE = link_pulse_oe;

endmodule
`default_nettype wire

// File: verilog/rx_backplane_regs.svh
// register map, field positions, codes and counts of the receive backplane block
//
// Overview of operation
// - 10000000 mode: slave timed from reference clock
// - 11000000 mode: slave, signaling out, 1.544
// - 11010000 mode: slave, signaling out, 2.048
// - 01000000 mode: master, own frame pulse
// - slave: data on rise, pulse on fall
// - master: data and pulse on rise
// - 00010011 drives data and signaling outputs; the code drives signaling in the 11000000 and 11010000 modes only
// - 00110000 framer: ESF, CRC-6 under mimic
// - 00000000 framer: SF framing
// - alarm detector: 00010000 ESF, 00000000 SF
// - signaling buffer: 00000100 ESF, 00000000 SF
`ifndef RX_BACKPLANE_REGS_SVH
`define RX_BACKPLANE_REGS_SVH
`default_nettype none

// register indices; byte address is four times the index
`define IDX_MODE        10'h001
`define IDX_PIN         10'h003
`define IDX_FRAMER      10'h020
`define IDX_ALARM       10'h02c
`define IDX_SIGBUF      10'h040
`define IDX_STATUS      10'h004
`define ADDR_OF(idx)    ({(idx), 2'b00})

// interface mode codes
`define MODE_SLAVE_REF  8'h80
`define MODE_SIG_1544   8'hc0
`define MODE_SIG_2048   8'hd0
`define MODE_MASTER     8'h40
// pin configuration codes
`define PIN_SLAVE_NORM  8'h13
`define PIN_MASTER_NORM 8'h10

// field positions
`define FRAMER_ESF_BIT  4
`define FRAMER_MIMIC_BIT 5
`define ALARM_ESF_BIT   4
`define SIGBUF_ESF_BIT  2
`define STAT_SEEN_BIT   0
`define STAT_CONS_BIT   4

// reset values
`define RST_MODE        8'hc0
`define RST_PIN         8'h00
`define RST_FMT         8'h00

// last bit index of a frame
`define FRAME_LAST_T1   9'h0c0
`define FRAME_LAST_2048 9'h0ff

`default_nettype wire
`endif

// File: verilog/rx_backplane_pkg.sv
// types shared by the receive backplane register block and its link side
`default_nettype none
package rx_backplane_pkg;

  // decoded receive interface mode
  typedef enum logic [2:0] {
    LINK_OFF       = 3'b000,
    LINK_SLAVE_REF = 3'b001,
    LINK_SIG_1544  = 3'b010,
    LINK_SIG_2048  = 3'b011,
    LINK_MASTER    = 3'b100
  } link_mode_type;

  // register selected by an APB address
  typedef enum logic [2:0] {
    SEL_NONE   = 3'b000,
    SEL_MODE   = 3'b001,
    SEL_PIN    = 3'b010,
    SEL_FRAMER = 3'b011,
    SEL_ALARM  = 3'b100,
    SEL_SIGBUF = 3'b101,
    SEL_STATUS = 3'b110
  } reg_sel_type;

  // configuration handed to the link clock domain
  typedef struct packed {
    link_mode_type mode;
    logic          data_en;
    logic          sig_en;
    logic          pulse_en;
  } link_cfg_type;

endpackage
`default_nettype wire

// File: verilog/rx_link_side.sv
// link clock side of the receive backplane: pin timing and frame counting
`include "rx_backplane_regs.svh"
`default_nettype none
module rx_link_side
(
  input  wire logic                        link_clk,
  input  wire logic                        rst,
  input  wire rx_backplane_pkg::link_cfg_type cfg,
  input  wire logic                        common_frame_pulse,
  input  wire logic                        payload_bit,
  input  wire logic                        signaling_bit,
  output logic                             data_out,
  output logic                             data_oe,
  output logic                             sig_out,
  output logic                             sig_oe,
  output logic                             pulse_out,
  output logic                             pulse_oe,
  output logic                             frame_toggle
);

  // all rising-edge link state in one record
  typedef struct packed {
    logic                         rst_s1;     // reset synchroniser
    logic                         rst_s2;
    rx_backplane_pkg::link_cfg_type cfg_s1;   // quasi-static config sync
    rx_backplane_pkg::link_cfg_type cfg_s2;
    logic [8:0]                   bit_cnt;    // bit position in frame
    logic                         data_out;
    logic                         data_oe;
    logic                         sig_out;
    logic                         sig_oe;
    logic                         pulse_out;
    logic                         pulse_oe;
    logic                         tog;        // flips at each frame start
  } link_state_type;

  link_state_type state;
  link_state_type next_state;
  logic           pulse_fall;   // frame pulse caught on falling edge

  always_ff @(negedge link_clk)
  begin
    pulse_fall <= common_frame_pulse;
  end

  // next link state
  always_comb
  begin
    logic       last;
    logic       start;
    logic [8:0] last_idx;
    next_state = state;
    next_state.rst_s1 = rst;
    next_state.rst_s2 = state.rst_s1;
    next_state.cfg_s1 = cfg;
    next_state.cfg_s2 = state.cfg_s1;
    last_idx = (state.cfg_s2.mode == rx_backplane_pkg::LINK_SIG_2048)
               ? `FRAME_LAST_2048 : `FRAME_LAST_T1;
    last = (state.bit_cnt >= last_idx);
    start = 1'b0;
    if (state.rst_s2)
    begin
      // hold every pin released while the reset is seen here
      next_state.bit_cnt   = 9'h000;
      next_state.data_out  = 1'b0;
      next_state.data_oe   = 1'b0;
      next_state.sig_out   = 1'b0;
      next_state.sig_oe    = 1'b0;
      next_state.pulse_out = 1'b0;
      next_state.pulse_oe  = 1'b0;
      next_state.tog       = 1'b0;
    end
    else
    begin
      case (state.cfg_s2.mode)
        rx_backplane_pkg::LINK_MASTER:
        begin
          start = last;
        end
        default:
        begin
          start = pulse_fall | last;
        end
      endcase
      next_state.bit_cnt = start ? 9'h000 : 9'(state.bit_cnt + 9'h001);
      next_state.pulse_out = (state.cfg_s2.mode == rx_backplane_pkg::LINK_MASTER)
                             & start;
      if (start)
      begin
        next_state.tog = ~state.tog;
      end
      next_state.data_out = payload_bit;
      next_state.sig_out  = state.cfg_s2.sig_en & signaling_bit;
      next_state.data_oe  = state.cfg_s2.data_en;
      next_state.sig_oe   = state.cfg_s2.sig_en;
      next_state.pulse_oe = state.cfg_s2.pulse_en;
    end
  end

  // register the link state
  always_ff @(posedge link_clk)
  begin
    state <= next_state;
  end

  assign data_out     = state.data_out;
  assign data_oe      = state.data_oe;
  assign sig_out      = state.sig_out;
  assign sig_oe       = state.sig_oe;
  assign pulse_out    = state.pulse_out;
  assign pulse_oe     = state.pulse_oe;
  assign frame_toggle = state.tog;

endmodule
`default_nettype wire

// File: testbench/rx_backplane_model.sv
// behavioural system backplane at the far side of the receive link
`default_nettype none
module rx_backplane_model
(
  input  wire logic link_clk,
  input  wire logic data_in,
  input  wire logic data_oe,
  output logic      frame_pulse,
  output logic      payload,
  output logic      signaling,
  output logic      seen_high
);
  logic [8:0] bit_pos;  // bit position in a 193 bit frame
  logic [7:0] pattern;  // shift pattern so data changes often
  initial
  begin
    bit_pos = 9'h000;
    pattern = 8'h5a;
    frame_pulse = 1'b0;
    payload = 1'b0;
    signaling = 1'b0;
    seen_high = 1'b0;
  end
  // launch on rise
  // pulse changes on the rise so the device's falling-edge sample sees it settled
  always @(posedge link_clk)
  begin
    bit_pos <= (bit_pos == 9'h0c0) ? 9'h000 : bit_pos + 9'h001;
    frame_pulse <= (bit_pos == 9'h0c0);
    pattern <= {pattern[6:0], pattern[7] ^ pattern[5]};
    payload <= pattern[0];
    signaling <= pattern[3];
    if (data_oe === 1'b1 && data_in === 1'b1) seen_high <= 1'b1;
  end
endmodule
`default_nettype wire

// File: testbench/rx_backplane_mode_config_asserts.sv
// concurrent checks on the ports of the receive backplane register block
`default_nettype none
module rx_backplane_mode_config_asserts
(
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        FRAMER_ESF,
  input wire logic        FRAMER_MIMIC_CRC,
  input wire logic        ALARM_ESF,
  input wire logic        SIGBUF_ESF,
  input wire logic        RX_LINK_CLOCK,
  input wire logic        RX_PAYLOAD_BIT,
  input wire logic        RX_SYSTEM_DATA_OUT,
  input wire logic        RX_SYSTEM_DATA_OE,
  input wire logic        RX_CHANNEL_FRAME_PULSE,
  input wire logic        RX_CHANNEL_FRAME_PULSE_OE
);
  wire wr_done = PSEL && PENABLE && PREADY && PWRITE;  // write taken at this edge
  ////////////////////////////////////////////////////////////////////////////////
  chk_ready_pulse: assert property (@(posedge CLK) disable iff (RST) PREADY |=> !PREADY)
    else $error("ready held longer than one cycle");
  chk_one_wait: assert property (@(posedge CLK) disable iff (RST)
    $rose(PSEL && PENABLE) |-> !PREADY ##1 PREADY) else $error("wait state count wrong");
  chk_err_read: assert property (@(posedge CLK) disable iff (RST)
    PSLVERR && !PWRITE |-> PREADY && PRDATA == 32'h0) else $error("refused read not empty");
  chk_framer_write: assert property (@(posedge CLK) disable iff (RST)
    wr_done && PADDR == 12'h080 |=> FRAMER_ESF == $past(PWDATA[4])
    && FRAMER_MIMIC_CRC == $past(PWDATA[5])) else $error("framer select not updated");
  chk_alarm_write: assert property (@(posedge CLK) disable iff (RST)
    wr_done && PADDR == 12'h0b0 |=> ALARM_ESF == $past(PWDATA[4]))
    else $error("alarm select not updated");
  chk_sigbuf_write: assert property (@(posedge CLK) disable iff (RST)
    wr_done && PADDR == 12'h100 |=> SIGBUF_ESF == $past(PWDATA[2]))
    else $error("signaling buffer select not updated");
  chk_data_follow: assert property (@(posedge RX_LINK_CLOCK) disable iff (RST)
    RX_SYSTEM_DATA_OE ##1 RX_SYSTEM_DATA_OE |-> RX_SYSTEM_DATA_OUT == $past(RX_PAYLOAD_BIT))
    else $error("data out does not follow payload");
  chk_pulse_single: assert property (@(posedge RX_LINK_CLOCK) disable iff (RST)
    RX_CHANNEL_FRAME_PULSE |-> RX_CHANNEL_FRAME_PULSE_OE ##1 !RX_CHANNEL_FRAME_PULSE)
    else $error("frame pulse too long or undriven");
  chk_pulse_period: assert property (@(posedge RX_LINK_CLOCK) disable iff (RST)
    $rose(RX_CHANNEL_FRAME_PULSE) |-> ##193
    (RX_CHANNEL_FRAME_PULSE || !RX_CHANNEL_FRAME_PULSE_OE)) else $error("frame period wrong");
endmodule
bind rx_backplane_mode_config rx_backplane_mode_config_asserts rx_backplane_mode_config_asserts_i
(
  .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .FRAMER_ESF(FRAMER_ESF), .FRAMER_MIMIC_CRC(FRAMER_MIMIC_CRC), .ALARM_ESF(ALARM_ESF),
  .SIGBUF_ESF(SIGBUF_ESF), .RX_LINK_CLOCK(RX_LINK_CLOCK), .RX_PAYLOAD_BIT(RX_PAYLOAD_BIT),
  .RX_SYSTEM_DATA_OUT(RX_SYSTEM_DATA_OUT), .RX_SYSTEM_DATA_OE(RX_SYSTEM_DATA_OE),
  .RX_CHANNEL_FRAME_PULSE(RX_CHANNEL_FRAME_PULSE),
  .RX_CHANNEL_FRAME_PULSE_OE(RX_CHANNEL_FRAME_PULSE_OE)
);
`default_nettype wire

// File: testbench/test_rx_backplane_mode_config.sv
// self-checking bench for the receive backplane register block
`default_nettype none
module test_rx_backplane_mode_config;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic        FRAMER_ESF, FRAMER_MIMIC_CRC, ALARM_ESF, SIGBUF_ESF, RX_LINK_CLOCK;
  logic        RX_COMMON_FRAME_PULSE, RX_PAYLOAD_BIT, RX_SIGNALING_BIT, seen_high;
  logic        RX_SYSTEM_DATA_OUT, RX_SYSTEM_DATA_OE, RX_SIGNALING_OUT, RX_SIGNALING_OE;
  logic        RX_CHANNEL_FRAME_PULSE, RX_CHANNEL_FRAME_PULSE_OE;
  logic [31:0] rdata;      // read data taken at the answer edge
  logic        rerr;       // error flag taken at the answer edge
  int          failures;   // mismatches seen
  int          cmp_count;  // comparisons made
  int          pulses;     // channel frame pulses seen
  // byte addresses: mode, pin, framer, alarm, signaling buffer
  logic [11:0] addr [5] = '{12'h004, 12'h00c, 12'h080, 12'h0b0, 12'h100};
  // one row per documented receive mode, same column order as addr
  logic [7:0]  tbl [4][5] = '{'{8'h80, 8'h13, 8'h30, 8'h10, 8'h04},
    '{8'hc0, 8'h13, 8'h30, 8'h10, 8'h04}, '{8'hd0, 8'h13, 8'h30, 8'h10, 8'h04},
    '{8'h40, 8'h10, 8'h00, 8'h00, 8'h00}};
  ////////////////////////////////////////////////////////////////////////////////
  rx_backplane_mode_config rx_backplane_mode_config_i (.*);
  rx_backplane_model rx_backplane_model_i (.link_clk(RX_LINK_CLOCK),
    .data_in(RX_SYSTEM_DATA_OUT), .data_oe(RX_SYSTEM_DATA_OE),
    .frame_pulse(RX_COMMON_FRAME_PULSE), .payload(RX_PAYLOAD_BIT),
    .signaling(RX_SIGNALING_BIT), .seen_high(seen_high));
  ////////////////////////////////////////////////////////////////////////////////
  // register clock, and a link clock with an unrelated phase
  initial
  begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  initial
  begin
    RX_LINK_CLOCK = 1'b0;
    #3;
    forever #32 RX_LINK_CLOCK = ~RX_LINK_CLOCK;
  end
  always @(posedge RX_LINK_CLOCK) if (RX_CHANNEL_FRAME_PULSE === 1'b1) pulses++;
  ////////////////////////////////////////////////////////////////////////////////
  // one APB transfer; entered right after a rising edge, waits for the answer
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1 && n < 20)
    begin
      @(posedge CLK);
      n++;
    end
    if (n == 20) failures++;
    rdata = PRDATA;
    rerr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH at %0t: word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // watchdog well past the expected run of about 32 us
  initial
  begin
    #400us;
    failures++;
    close_out();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {RST, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = {1'b1, 47'h0};
    // long reset so the link side sees it through its synchroniser
    repeat (32) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    // reset values and released pins
    foreach (addr[r])
    begin
      apb(1'b0, addr[r], 32'h0);
      chk32(rdata, (r == 0) ? 32'hc0 : 32'h0);
    end
    chk1(RX_SYSTEM_DATA_OE, 1'b0);
    chk1(FRAMER_ESF, 1'b0);
    for (int m = 0; m < 4; m++)
    begin
      foreach (addr[r]) apb(1'b1, addr[r], {24'h0, tbl[m][r]});
      foreach (addr[r])
      begin
        apb(1'b0, addr[r], 32'h0);
        chk32(rdata, {24'h0, tbl[m][r]});
      end
      chk1(FRAMER_ESF, tbl[m][2][4]);
      chk1(FRAMER_MIMIC_CRC, tbl[m][2][5]);
      chk1(ALARM_ESF, tbl[m][3][4]);
      chk1(SIGBUF_ESF, tbl[m][4][2]);
      // master mode stays long enough for two frames
      repeat ((m == 3) ? 3400 : 64) @(posedge CLK);
      chk1(RX_SYSTEM_DATA_OE, 1'b1);
      chk1(RX_SIGNALING_OE, m == 1 || m == 2);
      chk1(RX_CHANNEL_FRAME_PULSE_OE, m == 3);
      apb(1'b0, 12'h010, 32'h0);
      chk32(rdata & 32'h1e, {27'h1, 3'(m + 1), 1'b0});
    end
    chk1(pulses >= 2, 1'b1);
    chk1(seen_high, 1'b1);
    // inconsistent formats clear the consistency flag
    apb(1'b1, 12'h080, 32'h30);
    apb(1'b0, 12'h010, 32'h0);
    chk1(rdata[4], 1'b0);
    // undocumented mode code releases every pin
    apb(1'b1, 12'h004, 32'h0);
    repeat (64) @(posedge CLK);
    chk1(RX_SYSTEM_DATA_OE | RX_SIGNALING_OE | RX_CHANNEL_FRAME_PULSE_OE, 1'b0);
    // unmapped and misaligned places are refused
    apb(1'b0, 12'h200, 32'h0);
    chk1(rerr, 1'b1);
    chk32(rdata, 32'h0);
    apb(1'b1, 12'h005, 32'hff);
    chk1(rerr, 1'b1);
    // reset in mid-run restores the default mode
    RST <= 1'b1;
    repeat (32) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    apb(1'b0, 12'h004, 32'h0);
    chk32(rdata, 32'hc0);
    close_out();
  end
endmodule
`default_nettype wire
